// ==== rtl/opaddr_pkg.sv ====
package opaddr_pkg;
   // address widths
   localparam int OFFSET_W = 16;
   localparam int PHYS_W = 20;
   localparam int SEG_SHIFT = 4;
   // register file indices of the internal word registers
   localparam logic [2:0] IDX_GENERAL_BASE = 3'h0;
   localparam logic [2:0] IDX_STACK_BASE = 3'h1;
   localparam logic [2:0] IDX_SRC_INDEX = 3'h2;
   localparam logic [2:0] IDX_DEST_INDEX = 3'h3;
   localparam logic [2:0] IDX_PORT_INDEX = 3'h4;
   localparam int NUM_REGS = 5;
   // segment selects
   localparam logic [1:0] SEG_EXTRA = 2'h0;
   localparam logic [1:0] SEG_CODE = 2'h1;
   localparam logic [1:0] SEG_STACK = 2'h2;
   localparam logic [1:0] SEG_DATA = 2'h3;
   // value of every pointer register after reset
   localparam logic [15:0] REG_RESET = 16'h0000;
   // latency constant, not used by the logic; answers come two cycles after a request
   localparam int ADDR_LATENCY = 1;

   // addressing request kinds
   typedef enum logic [2:0]
   {
      MODE_DIRECT = 3'b000,       // displacement only
      MODE_BASED = 3'b001,        // base plus displacement
      MODE_INDEXED = 3'b010,      // index plus displacement
      MODE_BASED_INDEXED = 3'b011,
      MODE_STRING = 3'b100,       // implicit source and destination
      MODE_PORT_DIRECT = 3'b101,  // 8-bit immediate port
      MODE_PORT_INDIRECT = 3'b110 // port from port index register
   } addr_mode_t;
endpackage

// ==== rtl/pointer_regfile.sv ====
`timescale 1ns/1ns
`default_nettype none
// small pointer register file: two read ports, two write ports, registered reads
module pointer_regfile
   import opaddr_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 5
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] rd_a_sel,
   input wire logic [2:0] rd_b_sel,
   output logic [WIDTH-1:0] rd_a_data,
   output logic [WIDTH-1:0] rd_b_data,
   input wire logic wr_a_en,
   input wire logic [2:0] wr_a_sel,
   input wire logic [WIDTH-1:0] wr_a_data,
   input wire logic wr_b_en,
   input wire logic [2:0] wr_b_sel,
   input wire logic [WIDTH-1:0] wr_b_data
);
   logic [WIDTH-1:0] mem_reg [DEPTH];  // stored words
   logic [WIDTH-1:0] mem_next [DEPTH]; // next stored words
   logic [WIDTH-1:0] rd_a_next;        // read port a next
   logic [WIDTH-1:0] rd_b_next;        // read port b next

   // writes; port b wins a collision since it carries the string step
   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         mem_next[i] = mem_reg[i];
         if (wr_a_en && (int'(wr_a_sel) == i))
            mem_next[i] = wr_a_data;
         if (wr_b_en && (int'(wr_b_sel) == i))
            mem_next[i] = wr_b_data;
      end
      // out-of-range select reads zero
      rd_a_next = (int'(rd_a_sel) < DEPTH) ? mem_reg[rd_a_sel] : '0;
      rd_b_next = (int'(rd_b_sel) < DEPTH) ? mem_reg[rd_b_sel] : '0;
   end

   // register storage and read data
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_reg[i] <= WIDTH'(REG_RESET);
         rd_a_data <= '0;
         rd_b_data <= '0;
      end
      else
      begin
         mem_reg <= mem_next;
         rd_a_data <= rd_a_next;
         rd_b_data <= rd_b_next;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/operand_address_generator.sv ====
`timescale 1ns/1ns
`default_nettype none
// Contract
// RL1: based indexed: base plus index plus displacement
// RL2: strings use source and destination index implicitly
// RL3: repeated strings step both index registers
// RL4: direct port number from 8-bit immediate
// RL5: indirect port number from port index register
// RL6: memory-mapped ports reachable by every memory mode
// RL7: physical address is shifted segment plus offset
// RL8: offset is unsigned 16-bit byte distance
// RL9: stack base pointer selects stack segment
// RL10: offset sums wrap modulo 2^16
module operand_address_generator
   import opaddr_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic SRST,
   // address request
   input wire logic REQ_VALID,
   input wire logic [2:0] REQ_MODE,
   input wire logic REQ_BASE_IS_STACK,
   input wire logic REQ_INDEX_IS_DEST,
   input wire logic [15:0] REQ_DISP,
   input wire logic REQ_OVERRIDE,
   input wire logic [1:0] REQ_OVERRIDE_SEG,
   input wire logic REQ_STEP,
   input wire logic REQ_WORD,
   input wire logic REQ_DOWN,
   // pointer register writes from the execution side
   input wire logic REG_WR_EN,
   input wire logic [2:0] REG_WR_SEL,
   input wire logic [15:0] REG_WR_DATA,
   // segment register values
   input wire logic [15:0] SEG_EXTRA_VAL,
   input wire logic [15:0] SEG_CODE_VAL,
   input wire logic [15:0] SEG_STACK_VAL,
   input wire logic [15:0] SEG_DATA_VAL,
   // answer to the bus interface
   output logic ADDR_VALID,
   output logic ADDR_IS_IO,
   output logic [15:0] OPERAND_OFFSET,
   output logic [19:0] PHYS_ADDR,
   output logic [15:0] DEST_OFFSET,
   output logic [19:0] DEST_PHYS_ADDR,
   output logic [1:0] SEG_USED
);
   // pipeline of the request while the register file reads
   logic req_valid_reg;
   logic [2:0] mode_reg;
   logic base_stack_reg;
   logic [15:0] disp_reg;
   logic override_reg;
   logic [1:0] override_seg_reg;
   logic [15:0] seg_e_reg, seg_c_reg, seg_s_reg, seg_d_reg; // sampled segments
   logic [2:0] mode_next;
   // register file ports
   logic [2:0] rd_a_sel, rd_b_sel;
   logic [15:0] rd_a_data, rd_b_data;
   logic step_en;
   logic [15:0] step_amt; // element size of the pending step
   // answer registers
   logic addr_valid_reg, addr_valid_next;
   logic addr_io_reg, addr_io_next;
   logic [15:0] offset_reg, offset_next;
   logic [19:0] phys_reg, phys_next;
   logic [15:0] dest_off_reg, dest_off_next;
   logic [19:0] dest_phys_reg, dest_phys_next;
   logic [1:0] seg_used_reg, seg_used_next;

   // shifted segment plus offset, carry beyond 20 bits dropped
   function automatic logic [19:0] phys_of(input logic [15:0] seg, input logic [15:0] off);
      phys_of = 20'({seg, 4'h0}) + 20'(off); // RL7
   endfunction

   // pick a sampled segment value
   function automatic logic [15:0] seg_val(input logic [1:0] sel,
      input logic [15:0] e, input logic [15:0] c, input logic [15:0] s, input logic [15:0] d);
      case (sel)
         SEG_EXTRA: seg_val = e;
         SEG_CODE: seg_val = c;
         SEG_STACK: seg_val = s;
         default: seg_val = d;
      endcase
   endfunction

   // read selects: strings read both index registers, indirect ports the port index
   always_comb
   begin
      rd_a_sel = REQ_BASE_IS_STACK ? IDX_STACK_BASE : IDX_GENERAL_BASE;
      rd_b_sel = REQ_INDEX_IS_DEST ? IDX_DEST_INDEX : IDX_SRC_INDEX;
      mode_next = REQ_VALID ? REQ_MODE : 3'h0;
      case (addr_mode_t'(REQ_MODE))
         MODE_STRING:
         begin
            rd_a_sel = IDX_SRC_INDEX; // RL2
            rd_b_sel = IDX_DEST_INDEX; // RL2
         end
         MODE_PORT_INDIRECT:
            rd_a_sel = IDX_PORT_INDEX; // RL5
         default:
         begin
         end
      endcase
   end

   // string stepping: one element (byte or word) per accepted step, up or down
   always_comb
   begin
      step_en = REQ_VALID && (addr_mode_t'(REQ_MODE) == MODE_STRING) && REQ_STEP;
   end

   // step is applied one cycle later using the read data of that request;
   // size and direction are registered so a following request cannot bend it
   logic step_pend_reg;
   logic word_reg, down_reg;
   logic [15:0] src_new, dst_new;
   always_comb
   begin
      step_amt = word_reg ? 16'h0002 : 16'h0001;
      src_new = down_reg ? rd_a_data - step_amt : rd_a_data + step_amt; // RL3 RL10
      dst_new = down_reg ? rd_b_data - step_amt : rd_b_data + step_amt; // RL3 RL10
   end

   pointer_regfile #(.WIDTH(OFFSET_W), .DEPTH(NUM_REGS)) u_regs
   (
      .clk(CLOCK),
      .srst(SRST),
      .rd_a_sel(rd_a_sel),
      .rd_b_sel(rd_b_sel),
      .rd_a_data(rd_a_data),
      .rd_b_data(rd_b_data),
      .wr_a_en(step_pend_reg || REG_WR_EN),
      .wr_a_sel(step_pend_reg ? IDX_SRC_INDEX : REG_WR_SEL),
      .wr_a_data(step_pend_reg ? src_new : REG_WR_DATA),
      .wr_b_en(step_pend_reg),
      .wr_b_sel(IDX_DEST_INDEX),
      .wr_b_data(dst_new)
   );

   // offset and address formation from the read data
   always_comb
   begin
      logic [1:0] seg_def;
      logic [1:0] seg_sel;
      seg_def = SEG_DATA;
      seg_sel = SEG_DATA;
      addr_valid_next = req_valid_reg;
      addr_io_next = 1'b0;
      offset_next = disp_reg;
      dest_off_next = 16'h0000;
      case (addr_mode_t'(mode_reg))
         MODE_DIRECT:
            offset_next = disp_reg; // RL6 RL8
         MODE_BASED:
         begin
            offset_next = rd_a_data + disp_reg; // RL10
            if (base_stack_reg)
               seg_def = SEG_STACK; // RL9
         end
         MODE_INDEXED:
            offset_next = rd_b_data + disp_reg; // RL10
         MODE_BASED_INDEXED:
         begin
            offset_next = rd_a_data + rd_b_data + disp_reg; // RL1 RL10
            if (base_stack_reg)
               seg_def = SEG_STACK; // RL9
         end
         MODE_STRING:
         begin
            offset_next = rd_a_data; // RL2
            dest_off_next = rd_b_data; // RL2
         end
         MODE_PORT_DIRECT:
         begin
            addr_io_next = 1'b1;
            offset_next = {8'h00, disp_reg[7:0]}; // RL4
         end
         MODE_PORT_INDIRECT:
         begin
            addr_io_next = 1'b1;
            offset_next = rd_a_data; // RL5
         end
         default:
            addr_valid_next = 1'b0; // unknown mode gives no answer
      endcase
      // override applies to the source; string destination is fixed extra
      seg_sel = override_reg ? override_seg_reg : seg_def; // RL9
      seg_used_next = seg_sel;
      phys_next = addr_io_next ? 20'({4'h0, offset_next})
         : phys_of(seg_val(seg_sel, seg_e_reg, seg_c_reg, seg_s_reg, seg_d_reg),
                   offset_next); // RL7
      dest_phys_next = phys_of(seg_e_reg, dest_off_next); // RL7
   end

   // request pipeline and answer registers
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         req_valid_reg <= 1'b0;
         mode_reg <= 3'h0;
         base_stack_reg <= 1'b0;
         disp_reg <= 16'h0000;
         override_reg <= 1'b0;
         override_seg_reg <= 2'h0;
         seg_e_reg <= 16'h0000;
         seg_c_reg <= 16'h0000;
         seg_s_reg <= 16'h0000;
         seg_d_reg <= 16'h0000;
         step_pend_reg <= 1'b0;
         word_reg <= 1'b0;
         down_reg <= 1'b0;
         addr_valid_reg <= 1'b0;
         addr_io_reg <= 1'b0;
         offset_reg <= 16'h0000;
         phys_reg <= 20'h00000;
         dest_off_reg <= 16'h0000;
         dest_phys_reg <= 20'h00000;
         seg_used_reg <= 2'h0;
      end
      else
      begin
         req_valid_reg <= REQ_VALID;
         mode_reg <= mode_next;
         base_stack_reg <= REQ_BASE_IS_STACK;
         disp_reg <= REQ_DISP;
         override_reg <= REQ_OVERRIDE;
         override_seg_reg <= REQ_OVERRIDE_SEG;
         seg_e_reg <= SEG_EXTRA_VAL;
         seg_c_reg <= SEG_CODE_VAL;
         seg_s_reg <= SEG_STACK_VAL;
         seg_d_reg <= SEG_DATA_VAL;
         step_pend_reg <= step_en; // RL3
         word_reg <= REQ_WORD;
         down_reg <= REQ_DOWN;
         addr_valid_reg <= addr_valid_next;
         addr_io_reg <= addr_io_next;
         offset_reg <= offset_next;
         phys_reg <= phys_next;
         dest_off_reg <= dest_off_next;
         dest_phys_reg <= dest_phys_next;
         seg_used_reg <= seg_used_next;
      end
   end

   // all outputs straight from flip-flops
   assign ADDR_VALID = addr_valid_reg;
   assign ADDR_IS_IO = addr_io_reg;
   assign OPERAND_OFFSET = offset_reg;
   assign PHYS_ADDR = phys_reg;
   assign DEST_OFFSET = dest_off_reg;
   assign DEST_PHYS_ADDR = dest_phys_reg;
   assign SEG_USED = seg_used_reg;
endmodule
`default_nettype wire

// ==== tb/opaddr_checker_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
// watches answers against the requests that caused them
module opaddr_checker
   import opaddr_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic SRST,
   // request side
   input wire logic REQ_VALID,
   input wire logic [2:0] REQ_MODE,
   input wire logic REQ_BASE_IS_STACK,
   input wire logic [15:0] REQ_DISP,
   input wire logic REQ_OVERRIDE,
   input wire logic [15:0] SEG_EXTRA_VAL,
   input wire logic [15:0] SEG_CODE_VAL,
   input wire logic [15:0] SEG_STACK_VAL,
   input wire logic [15:0] SEG_DATA_VAL,
   // answer side
   input wire logic ADDR_VALID,
   input wire logic ADDR_IS_IO,
   input wire logic [15:0] OPERAND_OFFSET,
   input wire logic [19:0] PHYS_ADDR,
   input wire logic [15:0] DEST_OFFSET,
   input wire logic [19:0] DEST_PHYS_ADDR,
   input wire logic [1:0] SEG_USED
);
   // segments delayed two cycles, lined up with the answer
   logic [63:0] seg_d1_reg;
   logic [63:0] seg_d2_reg;
   logic [15:0] seg_now;
   always_ff @(posedge CLOCK)
   begin
      seg_d1_reg <= {SEG_EXTRA_VAL, SEG_CODE_VAL, SEG_STACK_VAL, SEG_DATA_VAL};
      seg_d2_reg <= seg_d1_reg;
   end
   assign seg_now = seg_d2_reg[16 * (3 - SEG_USED) +: 16];

   default clocking @(posedge CLOCK); endclocking
   default disable iff (SRST);

   chk_answer_late: assert property (REQ_VALID && REQ_MODE != 3'h7 |-> ##2 ADDR_VALID)
      else $error("answer missing");
   chk_stray_answer: assert property (ADDR_VALID |-> $past(REQ_VALID, 2))
      else $error("answer without request");
   chk_phys_sum: assert property (ADDR_VALID && !ADDR_IS_IO |->
      PHYS_ADDR == {seg_now, 4'h0} + {4'h0, OPERAND_OFFSET}) else $error("bad physical sum");
   chk_direct_offset: assert property (REQ_VALID && REQ_MODE == 3'h0 |->
      ##2 OPERAND_OFFSET == $past(REQ_DISP, 2)) else $error("bad direct offset");
   chk_port_byte: assert property (REQ_VALID && REQ_MODE == 3'h5 |-> ##2 ADDR_IS_IO &&
      OPERAND_OFFSET == ($past(REQ_DISP, 2) & 16'h00FF)) else $error("bad port number");
   chk_io_zero_ext: assert property (ADDR_VALID && ADDR_IS_IO |->
      PHYS_ADDR == {4'h0, OPERAND_OFFSET}) else $error("bad port address");
   chk_stack_seg: assert property (REQ_VALID && REQ_MODE == 3'h1 && REQ_BASE_IS_STACK &&
      !REQ_OVERRIDE |-> ##2 SEG_USED == SEG_STACK) else $error("stack segment missed");
   chk_dest_extra: assert property (REQ_VALID && REQ_MODE == 3'h4 |-> ##2
      DEST_PHYS_ADDR == {seg_d2_reg[63:48], 4'h0} + {4'h0, DEST_OFFSET})
      else $error("bad destination address");
endmodule
bind operand_address_generator opaddr_checker u_chk (.*);
`default_nettype wire

// ==== tb/biu_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// far side: turns each answer into one bus cycle
module biu_model
(
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic ADDR_VALID,
   output logic [15:0] n_cycles
);
   // only counts, the cycle timing itself is out of scope
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
         n_cycles <= 16'h0000;
      else if (ADDR_VALID)
         n_cycles <= n_cycles + 16'h0001;
   end
endmodule
`default_nettype wire

// ==== tb/operand_address_generator_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module operand_address_generator_test
   import opaddr_pkg::*;
;
   logic CLOCK, SRST, REQ_VALID, REQ_BASE_IS_STACK, REQ_INDEX_IS_DEST, REQ_OVERRIDE;
   logic REQ_STEP, REQ_WORD, REQ_DOWN, REG_WR_EN, ADDR_VALID, ADDR_IS_IO;
   logic [2:0] REQ_MODE, REG_WR_SEL;
   logic [1:0] REQ_OVERRIDE_SEG, SEG_USED;
   logic [15:0] REQ_DISP, REG_WR_DATA, OPERAND_OFFSET, DEST_OFFSET, n_cycles;
   logic [15:0] SEG_EXTRA_VAL, SEG_CODE_VAL, SEG_STACK_VAL, SEG_DATA_VAL;
   logic [19:0] PHYS_ADDR, DEST_PHYS_ADDR;
   logic [15:0] rg [5]; // shadow of the pointer registers
   int seed, checks, n_mismatch, n_req;

   operand_address_generator u_dut (.*);
   biu_model u_biu (.*);

   always #4 CLOCK = ~CLOCK;

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // shifted segment plus offset, wrapped to 20 bits
   function automatic logic [19:0] exp_phys(input logic [15:0] s, input logic [15:0] o);
      return {s, 4'h0} + {4'h0, o};
   endfunction

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // pointer write, never overlapping a request
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      @(negedge CLOCK);
      {REG_WR_EN, REG_WR_SEL, REG_WR_DATA} = {1'b1, s, d};
      rg[s] = d;
      @(negedge CLOCK);
      REG_WR_EN = 1'b0;
   endtask

   // one request from the current fields, answer checked against the shadow
   task automatic go;
      logic [15:0] b, x, off, dst, sv, st;
      logic [1:0] sg;
      int k;
      b = REQ_BASE_IS_STACK ? rg[1] : rg[0];
      x = REQ_INDEX_IS_DEST ? rg[3] : rg[2];
      dst = 16'h0000;
      st = REQ_WORD ? 16'h0002 : 16'h0001;
      case (REQ_MODE)
         3'h0: off = REQ_DISP;
         3'h1: off = b + REQ_DISP;
         3'h2: off = x + REQ_DISP;
         3'h3: off = b + x + REQ_DISP;
         3'h4:
         begin
            off = rg[2];
            dst = rg[3];
         end
         3'h5: off = {8'h00, REQ_DISP[7:0]};
         default: off = rg[4];
      endcase
      sg = (REQ_BASE_IS_STACK && REQ_MODE[0] && REQ_MODE < 3'h4) ? SEG_STACK : SEG_DATA;
      if (REQ_OVERRIDE)
         sg = REQ_OVERRIDE_SEG;
      sv = sg == 2'h0 ? SEG_EXTRA_VAL : sg == 2'h1 ? SEG_CODE_VAL :
         sg == 2'h2 ? SEG_STACK_VAL : SEG_DATA_VAL;
      REQ_VALID = 1'b1;
      @(negedge CLOCK);
      REQ_VALID = 1'b0;
      n_req++;
      if (REQ_MODE == 3'h4 && REQ_STEP)
      begin
         rg[2] = REQ_DOWN ? rg[2] - st : rg[2] + st;
         rg[3] = REQ_DOWN ? rg[3] - st : rg[3] + st;
      end
      k = 0;
      while (ADDR_VALID !== 1'b1 && k < 4)
      begin
         @(negedge CLOCK);
         k++;
      end
      chk(ADDR_VALID, 1'b1);
      chk(OPERAND_OFFSET, off);
      chk(ADDR_IS_IO, REQ_MODE > 3'h4);
      if (REQ_MODE < 3'h5)
      begin
         chk(PHYS_ADDR, exp_phys(sv, off));
         chk(SEG_USED, sg);
         chk(DEST_OFFSET, dst);
      end
      else
         chk(PHYS_ADDR, {4'h0, off});
      if (REQ_MODE == 3'h4)
         chk(DEST_PHYS_ADDR, exp_phys(SEG_EXTRA_VAL, dst));
      @(negedge CLOCK);
   endtask

   initial
   begin
      {CLOCK, SRST, REQ_VALID, REQ_BASE_IS_STACK, REQ_INDEX_IS_DEST} = 5'h08;
      {REQ_OVERRIDE, REQ_STEP, REQ_WORD, REQ_DOWN, REG_WR_EN} = 5'h00;
      {REQ_MODE, REG_WR_SEL, REQ_OVERRIDE_SEG} = 8'h00;
      {REQ_DISP, REG_WR_DATA, SEG_EXTRA_VAL, SEG_CODE_VAL, SEG_STACK_VAL, SEG_DATA_VAL} = 96'h0;
      foreach (rg[i]) rg[i] = REG_RESET;
      {seed, checks, n_mismatch, n_req} = {32'd14701, 96'h0};
      repeat (12) @(negedge CLOCK);
      SRST = 1'b0;
      chk(PHYS_ADDR, 20'h00000);
      // three-part sum carrying out of bit 15
      wr(3'h0, 16'hFFFF);
      wr(3'h3, 16'h0003);
      {REQ_MODE, REQ_INDEX_IS_DEST, REQ_DISP, SEG_DATA_VAL} = {3'h3, 1'b1, 32'h0002FFFF};
      go();
      // stack base, then the same with an override
      wr(3'h1, 16'h1234);
      {REQ_MODE, REQ_BASE_IS_STACK, SEG_STACK_VAL} = {3'h1, 1'b1, 16'h2000};
      go();
      {REQ_OVERRIDE, REQ_OVERRIDE_SEG} = {1'b1, SEG_CODE};
      go();
      // strings: word down twice, then byte up twice
      {REQ_MODE, REQ_OVERRIDE, REQ_STEP, REQ_WORD, REQ_DOWN} = {3'h4, 4'h7};
      go();
      go();
      {REQ_WORD, REQ_DOWN} = 2'b00;
      go();
      go();
      // both port forms at the top of their range
      {REQ_MODE, REQ_DISP} = {3'h5, 16'hABFF};
      go();
      wr(3'h4, 16'hFFFF);
      REQ_MODE = 3'h6;
      go();
      $display("directed tests done");
      // unused mode code must stay silent
      {REQ_MODE, REQ_VALID} = {3'h7, 1'b1};
      @(negedge CLOCK);
      REQ_VALID = 1'b0;
      repeat (3)
      begin
         @(negedge CLOCK);
         chk(ADDR_VALID, 1'b0);
      end
      $display("refusal test done");
      repeat (300)
      begin
         if ($random(seed) % 4 == 0)
            wr(3'($unsigned($random(seed)) % 5), 16'($random(seed)));
         {REQ_BASE_IS_STACK, REQ_INDEX_IS_DEST, REQ_OVERRIDE, REQ_STEP, REQ_WORD, REQ_DOWN,
            REQ_OVERRIDE_SEG} = 8'($random(seed));
         {REQ_DISP, SEG_EXTRA_VAL, SEG_CODE_VAL, SEG_STACK_VAL, SEG_DATA_VAL} =
            80'({$random(seed), $random(seed), $random(seed)});
         REQ_MODE = 3'($unsigned($random(seed)) % 7);
         if (REQ_MODE == 3'h4)
            REQ_OVERRIDE = 1'b0;
         go();
      end
      $display("random test done");
      chk(n_cycles, 16'(n_req));
      report_and_stop();
   end

   // whole run needs about 1100 cycles; this allows over 25 times that
   initial
   begin
      #240000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire
